/* common/irq_ctl_map.svh */
`ifndef IRQ_CTL_MAP_SVH
`define IRQ_CTL_MAP_SVH

// byte addresses on the register bus
`define ICR_OFF 32'h00000000
`define PCF_OFF 32'h00000004
`define PC_RISE_OFF 32'h00000008
`define PC_FALL_OFF 32'h0000000C
`define EXT_CFG_OFF 32'h00000010
`define IRQ_STAT_OFF 32'h00000014

// irq_control_reg field positions
`define ICR_GIE_BIT 7
`define ICR_PERIPH_GROUP_IRQ_ENABLE_BIT 6
`define ICR_TMR_IE_BIT 5
`define ICR_EXT_IE_BIT 4
`define ICR_PC_IE_BIT 3
`define ICR_TMR_F_BIT 2
`define ICR_EXT_F_BIT 1
`define ICR_PC_SUM_BIT 0

// ext_pin config and status field positions
`define EXT_RISE_BIT 0
`define STAT_IRQ_BIT 0
`define STAT_PERIPH_BIT 1

// reset values
`define ICR_RESET 8'h00
`define PCF_RESET 8'h00
`define PC_EDGE_RESET 8'h00
`define EXT_CFG_RESET 8'h01

`endif

/* common/irq_ctl_pkg.sv */
package irq_ctl_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef enum logic [2:0] {
    SEL_ICR,
    SEL_PCF,
    SEL_RISE,
    SEL_FALL,
    SEL_EXT,
    SEL_STAT,
    SEL_NONE
  } reg_sel_t;

endpackage

/* hdl/pin_change_bank.sv */
`include "irq_ctl_map.svh"

module pin_change_bank
  import irq_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] rise_en,
  input wire logic [7:0] fall_en,
  input wire logic clr_wr,
  input wire logic [7:0] clr_keep,
  output logic [7:0] pin_change_flag_regs,
  output logic any_change
);

  logic [7:0] prev_ff;
  logic armed_ff;
  logic [7:0] events;

  function automatic logic [7:0] edges(input logic [7:0] now, input logic [7:0] was,
                                        input logic [7:0] ren, input logic [7:0] fen);
    edges = (now & ~was & ren) | (~now & was & fen);
  endfunction

  // no edge is reported in the first cycle: prev_ff is not a real history yet
  assign events = armed_ff ? edges(pin_in, prev_ff, rise_en, fall_en) : 8'h00;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      prev_ff <= 8'h00;
      armed_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= pin_in;
      armed_ff <= 1'b1;
    end
  end

  // software clears by writing 0; a new edge in the same cycle wins
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      pin_change_flag_regs <= `PCF_RESET;
    else if (clr_wr)
      pin_change_flag_regs <= (pin_change_flag_regs & clr_keep) | events;
    else
      pin_change_flag_regs <= pin_change_flag_regs | events;
  end

  assign any_change = |pin_change_flag_regs;

endmodule // pin_change_bank

/* hdl/core_interrupt_control.sv */
`include "irq_ctl_map.svh"

// Notes on behaviour
// - bit 7 gates every request to core
// - bit 6 gates peripheral group requests
// - bit 5 enables timer overflow source
// - bit 4 enables external pin source
// - bit 3 enables pin-change source
// - bit 2 set on timer overflow
// - bit 1 set on external pin event
// - bit 0 shows any pin-change flag set
// - bit 0 read-only, clears with pin-change flags
// - flags set regardless of bits 7..3; pin-change flags need rise_en_ff or fall_en_ff set for the pin
// - whole register resets to zero
// - bits 7..1 writable, bit 0 ignores writes
module core_interrupt_control
  import irq_ctl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire apb_req_t apb_in,
  output apb_rsp_t apb_out,
  input wire logic timer_overflow,
  input wire logic ext_pin,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] periph_req,
  output logic irq_to_core,
  output logic [7:0] irq_control_reg
);

  logic [7:3] enables_ff;
  logic tmr_flag_ff;
  logic ext_flag_ff;
  logic [7:0] ctrl;
  logic [7:0] rise_en_ff;
  logic [7:0] fall_en_ff;
  logic [7:0] ext_cfg_ff;
  logic ext_prev_ff;
  logic ext_armed_ff;
  logic irq_ff;
  logic [31:0] rdata_ff;
  logic slverr_ff;
  logic [7:0] pc_flags;
  logic pc_sum;
  logic ext_event;
  logic setup;
  logic access_wr;
  reg_sel_t sel;
  logic [31:0] rd_value;
  logic local_req;
  logic periph_pending;
  logic nxt_irq;

  function automatic reg_sel_t decode(input logic [31:0] addr);
    case (addr)
      `ICR_OFF: decode = SEL_ICR;
      `PCF_OFF: decode = SEL_PCF;
      `PC_RISE_OFF: decode = SEL_RISE;
      `PC_FALL_OFF: decode = SEL_FALL;
      `EXT_CFG_OFF: decode = SEL_EXT;
      `IRQ_STAT_OFF: decode = SEL_STAT;
      default: decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic wr_hit(input apb_req_t req, input reg_sel_t which);
    wr_hit = req.psel && req.penable && req.pwrite && (decode(req.paddr) == which);
  endfunction

  assign sel = decode(apb_in.paddr);
  assign setup = apb_in.psel && !apb_in.penable;
  assign access_wr = apb_in.psel && apb_in.penable && apb_in.pwrite;

  // zero wait state slave: read data is captured in the setup cycle
  assign apb_out = '{pready: 1'b1, prdata: rdata_ff, pslverr: slverr_ff};

  pin_change_bank u_pin_change_bank (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin_in(pin_in),
    .rise_en(rise_en_ff),
    .fall_en(fall_en_ff),
    .clr_wr(wr_hit(apb_in, SEL_PCF)),
    .clr_keep(apb_in.pwdata[7:0]),
    .pin_change_flag_regs(pc_flags),
    .any_change(pc_sum)
  );

  // external pin edge detector, polarity chosen by software
  assign ext_event = ext_armed_ff &&
    (ext_cfg_ff[`EXT_RISE_BIT] ? (ext_pin && !ext_prev_ff) : (!ext_pin && ext_prev_ff));

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      ext_prev_ff <= 1'b0;
      ext_armed_ff <= 1'b0;
    end
    else
    begin
      ext_prev_ff <= ext_pin;
      ext_armed_ff <= 1'b1;
    end
  end

  // enable bits: plain storage from software
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      enables_ff <= 5'(`ICR_RESET >> 3);
    else if (wr_hit(apb_in, SEL_ICR))
      enables_ff <= apb_in.pwdata[7:3];
  end

  // timer flag: overflow sets it whatever the enables say, and wins over a write
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      tmr_flag_ff <= 1'b0;
    else if (timer_overflow)
      tmr_flag_ff <= 1'b1;
    else if (wr_hit(apb_in, SEL_ICR))
      tmr_flag_ff <= apb_in.pwdata[`ICR_TMR_F_BIT];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      ext_flag_ff <= 1'b0;
    else if (ext_event)
      ext_flag_ff <= 1'b1;
    else if (wr_hit(apb_in, SEL_ICR))
      ext_flag_ff <= apb_in.pwdata[`ICR_EXT_F_BIT];
  end

  // summary bit has no storage of its own, so a write cannot reach it
  assign ctrl = {enables_ff, tmr_flag_ff, ext_flag_ff, pc_sum};

  assign irq_control_reg = ctrl;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rise_en_ff <= `PC_EDGE_RESET;
      fall_en_ff <= `PC_EDGE_RESET;
      ext_cfg_ff <= `EXT_CFG_RESET;
    end
    else
    begin
      if (wr_hit(apb_in, SEL_RISE))
        rise_en_ff <= apb_in.pwdata[7:0];
      if (wr_hit(apb_in, SEL_FALL))
        fall_en_ff <= apb_in.pwdata[7:0];
      if (wr_hit(apb_in, SEL_EXT))
        ext_cfg_ff <= {7'h00, apb_in.pwdata[`EXT_RISE_BIT]};
    end
  end

  // request combining
  assign local_req = (ctrl[`ICR_TMR_IE_BIT] && ctrl[`ICR_TMR_F_BIT]) ||
                     (ctrl[`ICR_EXT_IE_BIT] && ctrl[`ICR_EXT_F_BIT]) ||
                     (ctrl[`ICR_PC_IE_BIT] && pc_sum);
  assign periph_pending = ctrl[`ICR_PERIPH_GROUP_IRQ_ENABLE_BIT] && (|periph_req);
  assign nxt_irq = ctrl[`ICR_GIE_BIT] && (local_req || periph_pending);

  // registered so the core sees a glitch-free level, at one cycle of latency
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      irq_ff <= 1'b0;
    else
      irq_ff <= nxt_irq;
  end

  assign irq_to_core = irq_ff;

  always_comb
  begin
    rd_value = 32'h00000000;
    case (sel)
      SEL_ICR: rd_value = {24'h000000, ctrl};
      SEL_PCF: rd_value = {24'h000000, pc_flags};
      SEL_RISE: rd_value = {24'h000000, rise_en_ff};
      SEL_FALL: rd_value = {24'h000000, fall_en_ff};
      SEL_EXT: rd_value = {24'h000000, ext_cfg_ff};
      SEL_STAT: rd_value = {30'h00000000, periph_pending, irq_ff};
      default: rd_value = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      rdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
    end
    else if (setup)
    begin
      rdata_ff <= apb_in.pwrite ? 32'h00000000 : rd_value;
      slverr_ff <= (sel == SEL_NONE);
    end
  end

  property p_gie_blocks;
    @(posedge sys_clk) disable iff (!rstn)
    !ctrl[`ICR_GIE_BIT] |=> !irq_to_core;
  endproperty
  a_gie_blocks: assert property (p_gie_blocks) else $error("request while disabled");

  property p_periph_path;
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl[`ICR_GIE_BIT] && !local_req) |=>
      (irq_to_core == $past(ctrl[`ICR_PERIPH_GROUP_IRQ_ENABLE_BIT] && (|periph_req)));
  endproperty
  a_periph_path: assert property (p_periph_path) else $error("peripheral gating wrong");

  property p_timer_src;
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl[`ICR_GIE_BIT] && ctrl[`ICR_TMR_IE_BIT] && ctrl[`ICR_TMR_F_BIT])
      |=> irq_to_core;
  endproperty
  a_timer_src: assert property (p_timer_src) else $error("timer source did not request");

  property p_ext_src;
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl[`ICR_GIE_BIT] && ctrl[`ICR_EXT_IE_BIT] && ctrl[`ICR_EXT_F_BIT])
      |=> irq_to_core;
  endproperty
  a_ext_src: assert property (p_ext_src) else $error("external source did not request");

  property p_pc_src;
    @(posedge sys_clk) disable iff (!rstn)
    (ctrl[`ICR_GIE_BIT] && ctrl[`ICR_PC_IE_BIT] && (|pc_flags)) |=> irq_to_core;
  endproperty
  a_pc_src: assert property (p_pc_src) else $error("pin-change source did not request");

  property p_timer_flag;
    @(posedge sys_clk) disable iff (!rstn)
    timer_overflow |=> ctrl[`ICR_TMR_F_BIT];
  endproperty
  a_timer_flag: assert property (p_timer_flag) else $error("overflow did not set flag");

  property p_timer_flag_rise;
    @(posedge sys_clk) disable iff (!rstn)
    $rose(ctrl[`ICR_TMR_F_BIT]) |-> $past(timer_overflow) || $past(access_wr);
  endproperty
  a_timer_flag_rise: assert property (p_timer_flag_rise) else $error("flag rose unasked");

  // the pin history restarts at reset, so an edge in the first cycle after release is skipped
  property p_ext_flag;
    @(posedge sys_clk) disable iff (!rstn)
    ($past(rstn) && (ext_cfg_ff[`EXT_RISE_BIT] ? (ext_pin && !$past(ext_pin))
                                                 : (!ext_pin && $past(ext_pin))))
      |=> irq_control_reg[`ICR_EXT_F_BIT];
  endproperty
  a_ext_flag: assert property (p_ext_flag) else $error("pin edge lost");

  property p_summary;
    @(posedge sys_clk) disable iff (!rstn)
    ($past(rstn) && (|((pin_in & ~$past(pin_in) & rise_en_ff) |
                       (~pin_in & $past(pin_in) & fall_en_ff))))
      |=> irq_control_reg[`ICR_PC_SUM_BIT];
  endproperty
  a_summary: assert property (p_summary) else $error("pin edge left summary clear");

  property p_summary_fall;
    @(posedge sys_clk) disable iff (!rstn)
    $fell(irq_control_reg[`ICR_PC_SUM_BIT]) |-> $past(wr_hit(apb_in, SEL_PCF));
  endproperty
  a_summary_fall: assert property (p_summary_fall) else $error("summary fell unasked");

  property p_flag_no_enable;
    @(posedge sys_clk) disable iff (!rstn)
    (timer_overflow && !ctrl[`ICR_GIE_BIT] && !ctrl[`ICR_TMR_IE_BIT])
      |=> ctrl[`ICR_TMR_F_BIT] && !irq_to_core;
  endproperty
  a_flag_no_enable: assert property (p_flag_no_enable) else $error("flag needs enable");

  property p_reset_zero;
    @(posedge sys_clk) disable iff (!rstn)
    $rose(rstn) |-> (ctrl[7:1] == 7'h00) && !irq_to_core;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("not zero after reset");

  property p_write_store;
    @(posedge sys_clk) disable iff (!rstn)
    (wr_hit(apb_in, SEL_ICR) && !timer_overflow && !ext_event) |=>
      (ctrl[7:1] == $past(apb_in.pwdata[7:1]));
  endproperty
  a_write_store: assert property (p_write_store) else $error("write not stored");

  property p_combine;
    @(posedge sys_clk) disable iff (!rstn)
    ##1 irq_to_core == $past(ctrl[`ICR_GIE_BIT] &&
      ((ctrl[`ICR_TMR_IE_BIT] && ctrl[`ICR_TMR_F_BIT]) ||
       (ctrl[`ICR_EXT_IE_BIT] && ctrl[`ICR_EXT_F_BIT]) ||
       (ctrl[`ICR_PC_IE_BIT] && (|pc_flags)) ||
       (ctrl[`ICR_PERIPH_GROUP_IRQ_ENABLE_BIT] && (|periph_req))));
  endproperty
  a_combine: assert property (p_combine) else $error("request equation broken");

endmodule // core_interrupt_control

/* tb/irq_sources.sv */
// stands in for the timer, the external pin, the pin-change pins and the peripheral group
module irq_sources
  import irq_ctl_pkg::*;
(
  input wire logic sys_clk,
  output logic timer_overflow,
  output logic ext_pin,
  output logic [7:0] pin_in,
  output logic [7:0] periph_req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    timer_overflow = 1'b0;
    ext_pin = 1'b0;
    pin_in = 8'h00;
    periph_req = 8'h00;
  end

  // overflow is a single-cycle pulse, as the timer makes it
  task automatic tick_timer();
    @(posedge sys_clk);
    timer_overflow <= 1'b1;
    @(posedge sys_clk);
    timer_overflow <= 1'b0;
  endtask

  task automatic set_ext(input logic v);
    @(posedge sys_clk);
    ext_pin <= v;
  endtask

  task automatic set_pins(input logic [7:0] v);
    @(posedge sys_clk);
    pin_in <= v;
  endtask

  task automatic set_periph(input logic [7:0] v);
    @(posedge sys_clk);
    periph_req <= v;
  endtask
endmodule // irq_sources

/* tb/tb_top.sv */
`include "irq_ctl_map.svh"

module tb_top
  import irq_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  apb_req_t req = '0;
  apb_rsp_t apb_out;
  logic timer_overflow, ext_pin, irq_to_core;
  logic [7:0] pin_in, periph_req, irq_control_reg;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;
  logic [8:0] tab [8] = '{9'h026, 9'h0A6, 9'h096, 9'h086, 9'h08E, 9'h1C6, 9'h186, 9'h146};

  always #25 sys_clk = ~sys_clk;

  core_interrupt_control core_interrupt_control_inst (
    .sys_clk(sys_clk), .rstn(rstn), .apb_in(req), .apb_out(apb_out),
    .timer_overflow(timer_overflow), .ext_pin(ext_pin), .pin_in(pin_in),
    .periph_req(periph_req), .irq_to_core(irq_to_core), .irq_control_reg(irq_control_reg));

  irq_sources irq_sources_inst (
    .sys_clk(sys_clk), .timer_overflow(timer_overflow), .ext_pin(ext_pin),
    .pin_in(pin_in), .periph_req(periph_req));

  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
    end
  endtask

  // held from setup until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do @(posedge sys_clk); while (apb_out.pready !== 1'b1);
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  function automatic logic exp_irq(input logic [7:0] v, input logic p);
    return v[7] & ((v[5] & v[2]) | (v[4] & v[1]) | (v[3] & v[0]) | (v[6] & p));
  endfunction

  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out();
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, `ICR_OFF, 32'h0);
    chk(rd, 32'h00000000);
    apb(1'b0, 32'h00000018, 32'h0);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
    // flags latch with every ICR enable still clear
    irq_sources_inst.tick_timer();
    irq_sources_inst.set_ext(1'b1);
    apb(1'b1, `PC_RISE_OFF, 32'h00000001);
    irq_sources_inst.set_pins(8'h01);
    settle();
    chk({24'h0, irq_control_reg}, 32'h00000007);
    chk({31'h0, irq_to_core}, 32'h00000000);
    apb(1'b0, `PCF_OFF, 32'h0);
    chk(rd, 32'h00000001);
    // enable combinations with all three flags pending
    for (int i = 0; i < 8; i++)
    begin
      irq_sources_inst.set_periph({7'h00, tab[i][8]});
      apb(1'b1, `ICR_OFF, {24'h0, tab[i][7:0]});
      settle();
      chk({31'h0, irq_to_core}, {31'h0, exp_irq(tab[i][7:0] | 8'h01, tab[i][8])});
    end
    irq_sources_inst.set_periph(8'h00);
    // software clears flags before any enable goes up
    apb(1'b1, `ICR_OFF, 32'h00000000);
    apb(1'b0, `ICR_OFF, 32'h0);
    chk(rd, 32'h00000001);
    apb(1'b1, `PCF_OFF, 32'h00000000);
    settle();
    chk({24'h0, irq_control_reg}, 32'h00000000);
    apb(1'b1, `ICR_OFF, 32'h000000FF);
    apb(1'b0, `ICR_OFF, 32'h0);
    chk(rd, 32'h000000FE);
    settle();
    chk({31'h0, irq_to_core}, 32'h00000001);
    apb(1'b0, `IRQ_STAT_OFF, 32'h0);
    chk(rd, 32'h00000001);
    // falling edges, on the external pin and on pin-change pin 0
    apb(1'b1, `EXT_CFG_OFF, 32'h00000000);
    apb(1'b1, `PC_FALL_OFF, 32'h00000001);
    apb(1'b1, `ICR_OFF, 32'h00000000);
    irq_sources_inst.set_ext(1'b0);
    irq_sources_inst.set_pins(8'h00);
    settle();
    chk({24'h0, irq_control_reg}, 32'h00000003);
    // a second reset in mid-run clears the control register and irq_to_core again
    @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, `ICR_OFF, 32'h0);
    chk(rd, 32'h00000000);
    chk({31'h0, irq_to_core}, 32'h00000000);
    close_out();
  end
endmodule // tb_top
